//--- dv/rc_mem_model.sv
`default_nettype none
module rc_mem_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire rc_pkg::rc_ireq_t i_ireq,
    output var rc_pkg::rc_iresp_t o_iresp,
    input wire rc_pkg::rc_dreq_t i_dreq,
    output var rc_pkg::rc_dresp_t o_dresp
);
    timeunit 1ns;
    timeprecision 1ps;
    import rc_pkg::*;
    logic [7:0] mem [0:255];
    logic [41:0] wlog [$];
    logic [1:0] wait_cnt = 2'h0;
    logic [31:0] fw;
    logic [7:0] a;
    initial o_iresp = '0;
    initial o_dresp = '0;
    function automatic logic [31:0] rd(input logic [7:0] p, input logic [1:0] sz);
        case (sz)
            2'h0: rd = {24'h0, mem[p]};
            2'h1: rd = {16'h0, mem[p], mem[p + 8'h1]};
            default: rd = {mem[p], mem[p + 8'h1], mem[p + 8'h2], mem[p + 8'h3]};
        endcase
    endfunction
    always @(posedge i_clk) begin
        fw = rd(i_ireq.addr[7:0], 2'h1);
        a = i_dreq.addr[7:0];
        o_iresp.valid <= i_ireq.req;
        // Idle lines toggle so a stale word is never mistaken for a fresh one
        o_iresp.insn <= i_ireq.req ? fw[15:0] : ~o_iresp.insn;
        if (!i_rst_n || o_dresp.ack || !i_dreq.req) begin
            o_dresp.ack <= 1'b0;
            o_dresp.rdata <= ~o_dresp.rdata;
            wait_cnt <= i_slow ? 2'h3 : 2'h0;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
            o_dresp.rdata <= ~o_dresp.rdata;
        end else begin
            o_dresp.ack <= 1'b1;
            o_dresp.rdata <= rd(a, i_dreq.size);
            if (i_dreq.we) begin
                case (i_dreq.size)
                    2'h0: wlog.push_back({2'h0, a, 24'h0, i_dreq.wdata[7:0]});
                    2'h1: wlog.push_back({2'h1, a, 16'h0, i_dreq.wdata[15:0]});
                    default: wlog.push_back({2'h2, a, i_dreq.wdata});
                endcase
                if (i_dreq.size == 2'h0) begin
                    mem[a] <= i_dreq.wdata[7:0];
                end
            end
        end
    end
endmodule // rc_mem_model
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic slow = 1'b0;
    rc_ireq_t ireq;
    rc_iresp_t iresp;
    rc_dreq_t dreq;
    rc_dresp_t dresp;
    logic [31:0] status;
    logic retire;
    int miscompares = 0;
    int num_checks = 0;
    logic [31:0] lfsr = 32'h3;
    // Program image; slots 1, 4, 10, 26 and 35 are patched with the run_one operands per pass
    logic [15:0] prog [0:35] = '{16'h2240, 16'h2100, 16'h6212, 16'h0015, 16'h4000, 16'h6202, 16'h7312,
        16'h6232, 16'h0317, 16'h1301, 16'hB002, 16'h6212, 16'hC000, 16'hC000, 16'h6232, 16'hA003,
        16'h2477, 16'h2499, 16'hC000, 16'hC000, 16'h6242, 16'h2048, 16'h91F0, 16'hA002, 16'h013A,
        16'hC000, 16'h0000, 16'h5500, 16'h6252, 16'h060F, 16'h6262, 16'h013D, 16'h070E, 16'h6272,
        16'hAFFE, 16'h3000};
    always #5 i_clk = ~i_clk;
    rc_core u_dut (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_ibus(ireq),
        .i_ibus(iresp),
        .o_dbus(dreq),
        .i_dbus(dresp),
        .o_status_word(status),
        .o_retire(retire)
    );
    rc_mem_model u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_slow(slow),
        .i_ireq(ireq),
        .o_iresp(iresp),
        .i_dreq(dreq),
        .o_dresp(dresp)
    );
    function automatic logic [31:0] rnd(input logic [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [41:0] lw(input logic [31:0] d);
        lw = {2'h2, 8'h40, d};
    endfunction
    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run_one(input logic [7:0] r8, input logic [7:0] u8, input logic [15:0] w,
                           input logic [7:0] m48, input logic [1:0] bcc);
        logic [31:0] s8;
        logic [31:0] s16;
        logic [31:0] s16p1;
        logic [31:0] p16;
        logic [63:0] acc;
        logic t;
        logic [41:0] exp [$];
        int n;
        s8 = {{24{r8[7]}}, r8};
        s16 = {{16{w[15]}}, w};
        s16p1 = s16 + 32'h1;
        p16 = 32'($signed(s8[15:0]) * $signed(s16p1[15:0]));
        acc = {32'h0, p16} + 64'($signed(s8) * $signed(s16p1));
        t = $signed(s16) >= $signed(s8);
        exp = '{lw(s8), lw(s8 & {24'h0, u8}), lw(s16)};
        // Taken when the flag matches the sense bit; a delayed form still runs its slot store
        if (t != bcc[1] || bcc[0]) begin
            exp.push_back(lw(s8));
        end
        exp.push_back(lw(s16p1));
        exp.push_back(lw(32'h77));
        exp.push_back({2'h0, 8'h48, 24'h0, m48 | 8'hF0});
        exp.push_back(lw({24'hFF_FFFF, m48 | 8'hF0}));
        exp.push_back(lw(p16));
        exp.push_back(lw(acc[63:32]));
        @(posedge i_clk);
        #1 i_rst_n = 1'b0;
        slow = lfsr[4];
        prog[1][7:0] = r8;
        prog[4][7:0] = u8;
        prog[10][9:8] = bcc;
        prog[26] = w;
        prog[35][7:0] = r8;
        for (int i = 0; i < 256; i++) begin
            u_mem.mem[i] = 8'hC0;
        end
        for (int i = 0; i < 36; i++) begin
            {u_mem.mem[2 * i], u_mem.mem[2 * i + 1]} = prog[i];
        end
        u_mem.mem[8'h48] = m48;
        u_mem.wlog.delete();
        repeat (16) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        n = 0;
        while (u_mem.wlog.size() < exp.size() && n < 600) begin
            @(posedge i_clk);
            n++;
        end
        repeat (20) @(posedge i_clk);
        chk(42'(u_mem.wlog.size()), 42'(exp.size()));
        for (int i = 0; i < exp.size() && i < u_mem.wlog.size(); i++) begin
            chk(u_mem.wlog[i], exp[i]);
        end
        chk(u_mem.wlog[exp.size() - 2], exp[exp.size() - 2]);
        chk(u_mem.wlog[exp.size() - 1], exp[exp.size() - 1]);
        // The closing loop slot compares the index register against the first immediate
        chk({10'h0, status}, {41'h0, s8 == 32'h48});
    endtask
    initial begin
        // Corner values first: sign boundaries, equal compare operands, each branch form
        run_one(8'h80, 8'hFF, 16'h8000, 8'h0F, 2'h0);
        run_one(8'h7F, 8'h00, 16'h007F, 8'hA5, 2'h3);
        run_one(8'hFF, 8'h5A, 16'hFFFF, 8'h00, 2'h2);
        run_one(8'h48, 8'h3C, 16'h1234, 8'h81, 2'h1);
        for (int k = 0; k < 8; k++) begin
            lfsr = rnd(lfsr);
            run_one(lfsr[7:0], lfsr[15:8], lfsr[31:16], lfsr[23:16], lfsr[9:8]);
        end
        tally_and_finish();
    end
    initial begin
        #150000;
        miscompares++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

//--- rtl/rc_core.sv
`default_nettype none
`include "rc_defs.svh"
module rc_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output var rc_pkg::rc_ireq_t o_ibus,
    input wire rc_pkg::rc_iresp_t i_ibus,
    output var rc_pkg::rc_dreq_t o_dbus,
    input wire rc_pkg::rc_dresp_t i_dbus,
    output var logic [31:0] o_status_word,
    output var logic o_retire
);
    import rc_pkg::*;

    rc_ireq_t ibus_reg, ibus_next;
    rc_dreq_t dreq_reg, dreq_next;
    rc_mstate_t mst_reg, mst_next;
    logic [31:0] arr_addr_reg, arr_addr_next;
    logic drop_reg, drop_next;
    logic [15:0] ir_reg, ir_next;
    logic ir_valid_reg, ir_valid_next;
    logic [31:0] ir_pc_reg, ir_pc_next, ir_npc_reg, ir_npc_next;
    logic stalled_reg, stalled_next;
    logic [31:0] sr_reg, sr_next;
    logic retire_reg, retire_next;
    logic [31:0] rf [16];

    logic [3:0] op, rn, rm, fn;
    logic [7:0] imm8;
    logic [1:0] lop;
    logic [31:0] rn_val, rm_val, r0_val, exec_pc;
    logic [31:0] m_addr;
    logic [1:0] m_size;
    logic arrive, stall, redirect, delayed, set_t, t_new;
    logic [31:0] redir_pc;
    logic rf_we;
    logic [3:0] rf_wa;
    logic [31:0] rf_wd;
    logic mac_start, mac_busy;
    rc_mop_t mac_op;
    logic [63:0] mac_val;

    function automatic logic [31:0] sext8(input logic [7:0] v);
        return {{24{v[7]}}, v};
    endfunction

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // Narrow loads always widen by sign
    function automatic logic [31:0] ld_ext(input logic [1:0] sz, input logic [31:0] d);
        if (sz == `RC_SZ_B) return sext8(d[7:0]);
        if (sz == `RC_SZ_W) return sext16(d[15:0]);
        return d;
    endfunction

    function automatic logic [31:0] logic_op(input logic [1:0] lo, input logic [31:0] a, input logic [31:0] b);
        unique case (lo)
            `RC_LOP_AND: return a & b;
            `RC_LOP_OR: return a | b;
            `RC_LOP_XOR: return a ^ b;
            `RC_LOP_TST: return a & b;
        endcase
    endfunction

    assign op = ir_reg[15:12];
    assign rn = ir_reg[11:8];
    assign rm = ir_reg[7:4];
    assign fn = ir_reg[3:0];
    assign imm8 = ir_reg[7:0];
    assign lop = ir_reg[9:8];
    assign rn_val = rf[rn];
    assign rm_val = rf[rm];
    assign r0_val = rf[`RC_IDX_REG];
    assign exec_pc = ir_pc_reg + `RC_PC_AHEAD;
    assign arrive = i_ibus.valid && !drop_reg;

    // Operand address and size of memory-touching instructions
    always_comb begin
        m_size = ir_reg[1:0];
        m_addr = rm_val;
        unique case (op)
            `RC_OP_LD: m_addr = rm_val + (ir_reg[`RC_IDX_BIT] ? r0_val : 32'h0);
            `RC_OP_ST: m_addr = rn_val + (ir_reg[`RC_IDX_BIT] ? r0_val : 32'h0);
            `RC_OP_LDPW: begin
                m_size = `RC_SZ_W;
                m_addr = exec_pc + {23'h0, imm8, 1'b0};
            end
            `RC_OP_LDPL: begin
                m_size = `RC_SZ_L;
                m_addr = {exec_pc[31:2], 2'b00} + {22'h0, imm8, 2'b00};
            end
            `RC_OP_BITM: begin
                m_size = `RC_SZ_B;
                m_addr = r0_val;
            end
            default: ;
        endcase
    end

    always_comb begin
        dreq_next = dreq_reg;
        mst_next = mst_reg;
        sr_next = sr_reg;
        rf_we = 1'b0;
        rf_wa = rn;
        rf_wd = 32'h0;
        mac_start = 1'b0;
        mac_op = rc_mop_t'(2'(fn - `RC_F_MULW));
        stall = 1'b0;
        redirect = 1'b0;
        delayed = 1'b0;
        redir_pc = exec_pc;
        set_t = 1'b0;
        t_new = 1'b0;
        if (ir_valid_reg) begin
            unique case (op)
                `RC_OP_ALU: begin
                    rf_we = 1'b1;
                    unique case (fn)
                        `RC_F_ADD: rf_wd = rn_val + rm_val;
                        `RC_F_SUB: rf_wd = rn_val - rm_val;
                        `RC_F_AND: rf_wd = rn_val & rm_val;
                        `RC_F_OR: rf_wd = rn_val | rm_val;
                        `RC_F_XOR: rf_wd = rn_val ^ rm_val;
                        `RC_F_MOV: rf_wd = rm_val;
                        `RC_F_ADDC: begin
                            set_t = 1'b1;
                            {t_new, rf_wd} = {1'b0, rn_val} + {1'b0, rm_val} + {32'h0, sr_reg[`RC_T_BIT]};
                        end
                        `RC_F_CMPEQ: begin
                            rf_we = 1'b0;
                            set_t = 1'b1;
                            t_new = (rn_val == rm_val);
                        end
                        `RC_F_CMPGE: begin
                            rf_we = 1'b0;
                            set_t = 1'b1;
                            t_new = ($signed(rn_val) >= $signed(rm_val));
                        end
                        `RC_F_TST: begin
                            rf_we = 1'b0;
                            set_t = 1'b1;
                            t_new = ((rn_val & rm_val) == 32'h0);
                        end
                        `RC_F_MULW, `RC_F_MACW, `RC_F_MULL, `RC_F_MACL: begin
                            rf_we = 1'b0;
                            // Interlock only when the multiplier is still busy
                            stall = mac_busy;
                            mac_start = !mac_busy;
                        end
                        `RC_F_STSH, `RC_F_STSL: begin
                            stall = mac_busy;
                            rf_wd = (fn == `RC_F_STSH) ? mac_val[63:32] : mac_val[31:0];
                        end
                    endcase
                end
                `RC_OP_ADDI: begin
                    rf_we = 1'b1;
                    rf_wd = rn_val + sext8(imm8);
                end
                `RC_OP_MOVI: begin
                    rf_we = 1'b1;
                    rf_wd = sext8(imm8);
                end
                `RC_OP_CMPI: begin
                    set_t = 1'b1;
                    t_new = (r0_val == sext8(imm8));
                end
                `RC_OP_LOGI: begin
                    rf_wa = `RC_IDX_REG;
                    if (lop == `RC_LOP_TST) begin
                        set_t = 1'b1;
                        t_new = ((r0_val & {24'h0, imm8}) == 32'h0);
                    end else begin
                        rf_we = 1'b1;
                        rf_wd = logic_op(lop, r0_val, {24'h0, imm8});
                    end
                end
                `RC_OP_LD, `RC_OP_ST, `RC_OP_LDPW, `RC_OP_LDPL, `RC_OP_BITM: begin
                    stall = 1'b1;
                    unique case (mst_reg)
                        MS_IDLE: begin
                            dreq_next = '{req: 1'b1, we: (op == `RC_OP_ST), size: m_size,
                                          addr: m_addr, wdata: rm_val};
                            mst_next = MS_ACC;
                        end
                        MS_ACC: if (i_dbus.ack) begin
                            dreq_next.req = 1'b0;
                            if (op == `RC_OP_BITM && lop != `RC_LOP_TST) begin
                                dreq_next = '{req: 1'b1, we: 1'b1, size: `RC_SZ_B, addr: m_addr,
                                              wdata: {24'h0, 8'(logic_op(lop, i_dbus.rdata, {24'h0, imm8}))}};
                                mst_next = MS_WR;
                            end else begin
                                stall = 1'b0;
                                mst_next = MS_IDLE;
                                if (op == `RC_OP_BITM) begin
                                    set_t = 1'b1;
                                    t_new = ((i_dbus.rdata[7:0] & imm8) == 8'h00);
                                end else if (op != `RC_OP_ST) begin
                                    rf_we = 1'b1;
                                    rf_wd = ld_ext(m_size, i_dbus.rdata);
                                end
                            end
                        end
                        MS_WR: if (i_dbus.ack) begin
                            dreq_next.req = 1'b0;
                            stall = 1'b0;
                            mst_next = MS_IDLE;
                        end
                    endcase
                end
                `RC_OP_JMP: begin
                    redirect = 1'b1;
                    delayed = 1'b1;
                    redir_pc = exec_pc + {{19{ir_reg[11]}}, ir_reg[11:0], 1'b0};
                end
                `RC_OP_BCC: begin
                    redir_pc = exec_pc + (sext8(imm8) << 1);
                    if (sr_reg[`RC_T_BIT] == ir_reg[`RC_BCC_SENSE]) begin
                        redirect = 1'b1;
                        delayed = ir_reg[`RC_BCC_DLY];
                    end
                end
                default: ;
            endcase
        end
        if (stall) begin
            rf_we = 1'b0;
            mac_start = 1'b0;
        end
        if (set_t && !stall) begin
            sr_next[`RC_T_BIT] = t_new;
        end
    end

    // Fetch and issue. A stalled instruction drops its in-flight fetches and refetches on
    // release; this costs two bubbles after a stall but keeps one word of fetch state.
    always_comb begin
        ibus_next = ibus_reg;
        arr_addr_next = ibus_reg.addr;
        drop_next = 1'b0;
        ir_next = ir_reg;
        ir_valid_next = ir_valid_reg;
        ir_pc_next = ir_pc_reg;
        ir_npc_next = ir_npc_reg;
        stalled_next = stall;
        retire_next = 1'b0;
        if (stall) begin
            ibus_next.req = 1'b0;
        end else begin
            retire_next = ir_valid_reg;
            ibus_next.req = 1'b1;
            ir_next = i_ibus.insn;
            ir_pc_next = arr_addr_reg;
            ir_npc_next = arr_addr_reg + `RC_INSN_BYTES;
            if (redirect || stalled_reg) begin
                ibus_next.addr = redirect ? redir_pc : ir_npc_reg;
                drop_next = 1'b1;
                ir_valid_next = delayed && arrive;
                if (delayed) begin
                    ir_npc_next = redir_pc;
                end
            end else begin
                ibus_next.addr = ibus_reg.addr + `RC_INSN_BYTES;
                ir_valid_next = arrive;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ibus_reg <= '{req: 1'b1, addr: `RC_PC_RESET};
            dreq_reg <= '0;
            mst_reg <= MS_IDLE;
            arr_addr_reg <= `RC_PC_RESET;
            drop_reg <= 1'b1;
            ir_reg <= 16'h0000;
            ir_valid_reg <= 1'b0;
            ir_pc_reg <= `RC_PC_RESET;
            ir_npc_reg <= `RC_PC_RESET;
            stalled_reg <= 1'b0;
            sr_reg <= `RC_SR_RESET;
            retire_reg <= 1'b0;
        end else begin
            ibus_reg <= ibus_next;
            dreq_reg <= dreq_next;
            mst_reg <= mst_next;
            arr_addr_reg <= arr_addr_next;
            drop_reg <= drop_next;
            ir_reg <= ir_next;
            ir_valid_reg <= ir_valid_next;
            ir_pc_reg <= ir_pc_next;
            ir_npc_reg <= ir_npc_next;
            stalled_reg <= stalled_next;
            sr_reg <= sr_next;
            retire_reg <= retire_next;
        end
    end

    // Register file holds data only, so it has no reset
    always_ff @(posedge i_clk) begin
        if (rf_we) begin
            rf[rf_wa] <= rf_wd;
        end
    end

    rc_mac u_mac (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(mac_start),
        .i_op(mac_op),
        .i_a(rn_val),
        .i_b(rm_val),
        .o_busy(mac_busy),
        .o_mac(mac_val)
    );

    assign o_ibus = ibus_reg;
    assign o_dbus = dreq_reg;
    assign o_status_word = sr_reg;
    assign o_retire = retire_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic exec_now;
    assign exec_now = ir_valid_reg && !stall;

    sequence slot_issues;
        ir_valid_reg && ir_pc_reg == $past(ir_pc_reg) + `RC_INSN_BYTES;
    endsequence
    sequence slot_flushed;
        !ir_valid_reg [*2];
    endsequence

    fetch_stride_a: assert property (
        ibus_reg.req && !stall && !redirect && !stalled_reg |=> ibus_reg.addr == $past(ibus_reg.addr) + 32'h2)
        else $error("fetch did not step one halfword");
    basic_rate_a: assert property (exec_now && op == `RC_OP_ADDI |=> o_retire)
        else $error("basic instruction did not retire next cycle");
    load_sext_a: assert property (
        exec_now && op == `RC_OP_LD && m_size == `RC_SZ_B && mst_reg == MS_ACC
        |=> rf[$past(rn)] == sext8($past(i_dbus.rdata[7:0])))
        else $error("byte load not sign extended");
    logic_zext_a: assert property (
        exec_now && op == `RC_OP_LOGI && lop == `RC_LOP_AND |=> rf[`RC_IDX_REG][31:8] == 24'h0)
        else $error("logical immediate not zero extended");
    add_keeps_flag_a: assert property (exec_now && op == `RC_OP_ADDI |=> $stable(sr_reg))
        else $error("add changed status word");
    cmp_flag_a: assert property (
        exec_now && op == `RC_OP_CMPI |=> sr_reg[0] == ($past(r0_val) == sext8($past(imm8)))
        && sr_reg[31:1] == $past(sr_reg[31:1]))
        else $error("compare flag wrong");
    delay_slot_a: assert property (
        exec_now && redirect && delayed && arrive |=> slot_issues)
        else $error("delay slot not issued");
    nodelay_flush_a: assert property (exec_now && redirect && !delayed |=> slot_flushed)
        else $error("immediate branch ran following instruction");
    flag_branch_a: assert property (
        exec_now && op == `RC_OP_BCC |-> redirect == (sr_reg[0] == ir_reg[9]))
        else $error("branch decision ignores flag");
endmodule // rc_core
`default_nettype wire

//--- rtl/rc_defs.svh
`ifndef RC_DEFS_SVH
`define RC_DEFS_SVH

`define RC_INSN_W 16
`define RC_INSN_BYTES 32'h0000_0002
`define RC_PC_AHEAD 32'h0000_0004
`define RC_PC_RESET 32'h0000_0000
`define RC_SR_RESET 32'h0000_0000
`define RC_T_BIT 0
`define RC_IDX_REG 4'h0

// Major opcode in bits 15:12
`define RC_OP_ALU 4'h0
`define RC_OP_ADDI 4'h1
`define RC_OP_MOVI 4'h2
`define RC_OP_CMPI 4'h3
`define RC_OP_LOGI 4'h4
`define RC_OP_LD 4'h5
`define RC_OP_ST 4'h6
`define RC_OP_LDPW 4'h7
`define RC_OP_LDPL 4'h8
`define RC_OP_BITM 4'h9
`define RC_OP_JMP 4'hA
`define RC_OP_BCC 4'hB

// Register-register function in bits 3:0
`define RC_F_ADD 4'h0
`define RC_F_SUB 4'h1
`define RC_F_AND 4'h2
`define RC_F_OR 4'h3
`define RC_F_XOR 4'h4
`define RC_F_MOV 4'h5
`define RC_F_CMPEQ 4'h6
`define RC_F_CMPGE 4'h7
`define RC_F_ADDC 4'h8
`define RC_F_TST 4'h9
`define RC_F_MULW 4'hA
`define RC_F_MACW 4'hB
`define RC_F_MULL 4'hC
`define RC_F_MACL 4'hD
`define RC_F_STSH 4'hE
`define RC_F_STSL 4'hF

// Logic sub-op in bits 9:8 of immediate and memory logic
`define RC_LOP_AND 2'h0
`define RC_LOP_OR 2'h1
`define RC_LOP_XOR 2'h2
`define RC_LOP_TST 2'h3

`define RC_SZ_B 2'h0
`define RC_SZ_W 2'h1
`define RC_SZ_L 2'h2
`define RC_IDX_BIT 2
`define RC_BCC_SENSE 9
`define RC_BCC_DLY 8

// Multiplier latency, issue to result visible
`define RC_LAT_MULW 3'h2
`define RC_LAT_MACW 3'h3
`define RC_LAT_MULL 3'h3
`define RC_LAT_MACL 3'h4
`endif

//--- rtl/rc_mac.sv
`default_nettype none
`include "rc_defs.svh"
module rc_mac (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire rc_pkg::rc_mop_t i_op,
    input wire logic [31:0] i_a,
    input wire logic [31:0] i_b,
    output logic o_busy,
    output logic [63:0] o_mac
);
    import rc_pkg::*;

    logic [2:0] cnt_reg, cnt_next;
    logic [63:0] mac_reg, mac_next, res_reg, res_next;
    logic [31:0] p16;
    logic [63:0] p32;

    function automatic logic [2:0] lat(input rc_mop_t op);
        unique case (op)
            RC_MUL_W: return `RC_LAT_MULW;
            RC_MAC_W: return `RC_LAT_MACW;
            RC_MUL_L: return `RC_LAT_MULL;
            RC_MAC_L: return `RC_LAT_MACL;
        endcase
    endfunction

    assign p16 = 32'($signed(i_a[15:0]) * $signed(i_b[15:0]));
    assign p32 = 64'($signed(i_a) * $signed(i_b));
    assign o_busy = (cnt_reg != 3'h0);
    assign o_mac = mac_reg;

    // Result is computed at issue and published after the latency, so the core sees a fixed delay
    always_comb begin
        cnt_next = cnt_reg;
        mac_next = mac_reg;
        res_next = res_reg;
        if (i_start && !o_busy) begin
            cnt_next = 3'(lat(i_op) - 3'h1);
            unique case (i_op)
                RC_MUL_W: res_next = {mac_reg[63:32], p16};
                RC_MAC_W: res_next = mac_reg + {{32{p16[31]}}, p16};
                RC_MUL_L: res_next = p32;
                RC_MAC_L: res_next = mac_reg + p32;
            endcase
        end else if (cnt_reg == 3'h1) begin
            cnt_next = 3'h0;
            mac_next = res_reg;
        end else if (o_busy) begin
            cnt_next = cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= 3'h0;
            mac_reg <= 64'h0;
            res_reg <= 64'h0;
        end else begin
            cnt_reg <= cnt_next;
            mac_reg <= mac_next;
            res_reg <= res_next;
        end
    end

    mulw_latency_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_start && !o_busy && i_op == RC_MUL_W |=> o_busy ##1 !o_busy)
        else $error("short multiply latency wrong");
    macl_latency_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_start && !o_busy && i_op == RC_MAC_L |=> o_busy [*3] ##1 (!o_busy && o_mac == $past(res_reg)))
        else $error("long accumulate latency wrong");
endmodule // rc_mac
`default_nettype wire

//--- rtl/rc_pkg.sv
`default_nettype none
`include "rc_defs.svh"
package rc_pkg;
    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } rc_ireq_t;
    typedef struct packed {
        logic valid;
        logic [`RC_INSN_W-1:0] insn;
    } rc_iresp_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rc_dreq_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } rc_dresp_t;
    typedef enum logic [1:0] {RC_MUL_W, RC_MAC_W, RC_MUL_L, RC_MAC_L} rc_mop_t;
    typedef enum logic [1:0] {MS_IDLE, MS_ACC, MS_WR} rc_mstate_t;
endpackage : rc_pkg
`default_nettype wire
